// >>> verilog/vpkt_pkg.sv
// Constants for the version context packet builder
package vpkt_pkg;
  // Header fields
  localparam logic [3:0]  PKT_TYPE_VERSION   = 4'h4;
  localparam int          HDR_TYPE_LSB       = 28;
  localparam int          HDR_CLASSID_BIT    = 27;
  localparam int          HDR_TSM_BIT        = 24;
  localparam int          HDR_TSI_LSB        = 22;
  localparam int          HDR_TSF_LSB        = 20;
  localparam int          HDR_SEQ_LSB        = 16;
  localparam logic [1:0]  FRAC_TIME_REALTIME = 2'h2;
  localparam logic [15:0] PKT_SIZE_WORDS     = 16'h000b;
  localparam logic [3:0]  PKT_LAST_IDX       = 4'ha;
  // Class identifier
  localparam logic [15:0] PKT_CLASS_VERSION  = 16'h0004;
  localparam logic [15:0] INFO_CLASS_DEFAULT = 16'h0001;
  // Arbitrary neutral organisation identifier
  localparam logic [23:0] ORG_ID_DEFAULT     = 24'h000000;
  // Command packet classes
  localparam logic [15:0] CMD_CLASS_SAMPLE   = 16'h0005;
  localparam logic [15:0] CMD_CLASS_REALTIME = 16'h0006;
  // Context indicators and version
  localparam logic [31:0] CIF_FIRST_CHANGED  = 32'h80000002;
  localparam logic [31:0] CIF_FIRST_STEADY   = 32'h00000002;
  localparam logic [31:0] CIF_SECOND_VALUE   = 32'h0000000c;
  localparam logic [31:0] PROTO_VERSION      = 32'h00000004;
  localparam int          VER_YEAR_LSB       = 25;
  localparam int          VER_DAY_LSB        = 16;
  localparam int          VER_REV_LSB        = 10;
  localparam int          VER_TYPE_LSB       = 6;
  localparam logic [3:0]  DEVICE_TYPE_NONE   = 4'h0;
  localparam logic [5:0]  IFREV_MAJOR1       = 6'h00;
  localparam logic [5:0]  IFREV_RSVD_MAX     = 6'h1f;
  localparam logic [6:0]  BUILD_YEAR_RST     = 7'h00;
  localparam logic [8:0]  BUILD_DAY_RST      = 9'h001;
  localparam logic [5:0]  BUILD_REV_RST      = 6'h01;
  // Register byte offsets
  localparam logic [7:0]  REG_CTRL           = 8'h00;
  localparam logic [7:0]  REG_STREAM_ID      = 8'h04;
  localparam logic [7:0]  REG_BUILD          = 8'h08;
  localparam logic [7:0]  REG_STATUS         = 8'h0c;
  localparam logic [7:0]  REG_PEER_VER       = 8'h10;
  localparam logic [7:0]  REG_PEER_BUILD     = 8'h14;
  localparam logic [7:0]  REG_ORG_ID         = 8'h18;
  // Time base
  localparam int          CLK_PERIOD_PS      = 5000;
  localparam logic [63:0] PS_PER_SECOND      = 64'd1000000000000;
endpackage

// >>> verilog/vpkt_rx_check.sv
// Receive checker for an incoming version context packet
`timescale 1ns/1ps
`default_nettype none
module vpkt_rx_check
  import vpkt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Word stream in
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  input  wire logic [31:0] rx_data,
  // Result
  output logic             done_r,
  output logic             good_r,
  output logic [31:0]      peer_ver_r,
  output logic [31:0]      peer_build_r,
  output logic             compat_r
);
  logic [3:0]  idx_r;
  logic        ok_r;
  logic        word_ok;
  logic [31:0] ver_seen_r;

  // Expected fixed fields, word by word
  assign word_ok =
      (idx_r == 4'h0) ? (rx_data[31:28] == PKT_TYPE_VERSION && rx_data[15:0] == PKT_SIZE_WORDS) :
      (idx_r == 4'h2) ? (rx_data[31:27] == 5'h00) :
      (idx_r == 4'h3) ? (rx_data[15:0] == PKT_CLASS_VERSION) :
      (idx_r == 4'h7) ? (rx_data == CIF_FIRST_CHANGED || rx_data == CIF_FIRST_STEADY) :
      (idx_r == 4'h8) ? (rx_data == CIF_SECOND_VALUE) :
      (idx_r == 4'ha) ? (rx_data[5:0] <= IFREV_RSVD_MAX) :
      1'b1;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      idx_r        <= 4'h0;
      ok_r         <= 1'b1;
      done_r       <= 1'b0;
      good_r       <= 1'b0;
      ver_seen_r   <= 32'h0;
      peer_ver_r   <= 32'h0;
      peer_build_r <= 32'h0;
      compat_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (rx_valid) begin
        if (idx_r == 4'h9) begin
          ver_seen_r <= rx_data;
        end
        if (rx_last) begin
          idx_r  <= 4'h0;
          ok_r   <= 1'b1;
          done_r <= 1'b1;
          // Short or long packets are rejected whole
          good_r <= ok_r && word_ok && (idx_r == PKT_LAST_IDX);
          if (ok_r && word_ok && idx_r == PKT_LAST_IDX) begin
            peer_ver_r   <= ver_seen_r;
            peer_build_r <= rx_data;
            // Only major 1 is understood; anything else leaves us incompatible
            compat_r     <= (ver_seen_r == PROTO_VERSION) && (rx_data[5:0] == IFREV_MAJOR1);
          end
        end else begin
          idx_r <= (idx_r == 4'hf) ? idx_r : idx_r + 4'h1;
          ok_r  <= ok_r && word_ok;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/vpkt_builder.sv
// Version context packet builder with Wishbone registers
//
// Overview of operation
// - Header packet type is 0x4.
// - Header timestamp mode bit is one, coarse timing.
// - Fractional timestamp type coded 0x2, real time picoseconds.
// - Header size field is eleven words.
// - Pad bit count in first class word is zero.
// - Packet class code 0x0004 in low half of second class word.
// - Fractional timestamp counts picoseconds beyond the integer second.
// - First indicator 0x80000002 after a context change, else 0x00000002.
// - Second indicator word is constant 0x0000000C.
// - Protocol version word is 0x4.
// - Version bits 31..25 hold build year minus 2000.
// - Version bits 24..16 hold build day, January first is one.
// - Version bits 15..10 hold same-day revision, normally one.
// - Device type bits 9..6 are zero.
// - Interface revision bits 5..0 are zero; codes 1..31 never sent.
// - Received version info selects a compatible mode where possible; here it only drives PEER_COMPAT and the status compat bit.
// - Only control command sub-type used; no acknowledge packets.
// - Command packets carry only class codes 0x0005 or 0x0006.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module vpkt_builder
  import vpkt_pkg::*;
#(
  parameter int CLK_PS = CLK_PERIOD_PS
)
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // Outgoing packet words
  output logic             TX_VALID,
  output logic             TX_LAST,
  output logic [31:0]      TX_DATA,
  input  wire logic        TX_READY,
  // Incoming packet words
  input  wire logic        RX_VALID,
  input  wire logic        RX_LAST,
  input  wire logic [31:0] RX_DATA,
  // Mode chosen from peer version
  output logic             PEER_COMPAT
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } tx_state_t;

  tx_state_t   state_r, state_nxt;
  logic [3:0]  idx_r;
  logic [31:0] stream_id_r;
  logic [31:0] org_id_r;
  logic [6:0]  year_r;
  logic [8:0]  day_r;
  logic [5:0]  rev_r;
  logic        changed_r;
  logic [3:0]  seq_r;
  logic [1:0]  tsi_r;
  logic [31:0] sec_r;
  logic [63:0] ps_r;
  logic [31:0] sec_snap_r;
  logic [63:0] ps_snap_r;
  logic        chg_snap_r;
  logic [15:0] sent_cnt_r;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Bus decode
  wire         wb_req    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire         wb_wr     = wb_req && WB_WE_I;
  wire         at_ctrl   = (WB_ADR_I == REG_CTRL);
  wire         at_sid    = (WB_ADR_I == REG_STREAM_ID);
  wire         at_build  = (WB_ADR_I == REG_BUILD);
  wire         at_status = (WB_ADR_I == REG_STATUS);
  wire         at_pver   = (WB_ADR_I == REG_PEER_VER);
  wire         at_pbuild = (WB_ADR_I == REG_PEER_BUILD);
  wire         at_org    = (WB_ADR_I == REG_ORG_ID);
  wire         wr_ctrl   = wb_wr && at_ctrl;
  wire         wr_sid    = wb_wr && at_sid;
  wire         wr_build  = wb_wr && at_build;
  wire         wr_org    = wb_wr && at_org;
  wire         start_req = wr_ctrl && WB_SEL_I[0] && WB_DAT_I[0];
  wire         mark_chg  = wr_ctrl && WB_SEL_I[0] && WB_DAT_I[1];
  wire [31:0]  build_now = {year_r, day_r, rev_r, 10'h000};
  wire [31:0]  build_new = merge(build_now, WB_DAT_I, WB_SEL_I);
  wire [31:0]  sid_new   = merge(stream_id_r, WB_DAT_I, WB_SEL_I);
  wire [31:0]  org_new   = merge(org_id_r, WB_DAT_I, WB_SEL_I);
  wire         busy      = (state_r == ST_SEND);

  // Receive side
  logic        rx_done;
  logic        rx_good;
  logic [31:0] peer_ver;
  logic [31:0] peer_build;
  logic        rx_compat;

  vpkt_rx_check u_rx (
    .clk          (REF_CLK),
    .nrst         (NRST),
    .rx_valid     (RX_VALID),
    .rx_last      (RX_LAST),
    .rx_data      (RX_DATA),
    .done_r       (rx_done),
    .good_r       (rx_good),
    .peer_ver_r   (peer_ver),
    .peer_build_r (peer_build),
    .compat_r     (rx_compat)
  );

  logic rx_good_seen_r;
  logic rx_bad_seen_r;

  // Unmapped offsets read zero; writes to them are dropped but still acked
  wire [31:0] rd_data =
      at_ctrl   ? {30'h0, changed_r, 1'b0} :
      at_sid    ? stream_id_r :
      at_build  ? build_now :
      at_status ? {sent_cnt_r, 12'h000, rx_bad_seen_r, rx_good_seen_r, rx_compat, busy} :
      at_pver   ? peer_ver :
      at_pbuild ? peer_build :
      at_org    ? org_id_r :
      32'h0;

  // One wait state; ack falls after one cycle even if the strobe stays up
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
    end
  end

  // Data is zero outside the answer cycle
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      WB_DAT_O <= 32'h0;
    end else begin
      WB_DAT_O <= wb_req ? rd_data : 32'h0;
    end
  end

  // Software registers
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      stream_id_r <= 32'h0;
    end else if (wr_sid) begin
      stream_id_r <= sid_new;
    end
  end

  // Only 24 bits of the organisation word exist; the top byte reads zero
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      org_id_r <= {8'h00, ORG_ID_DEFAULT};
    end else if (wr_org) begin
      org_id_r <= {8'h00, org_new[23:0]};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      year_r <= BUILD_YEAR_RST;
      day_r  <= BUILD_DAY_RST;
      rev_r  <= BUILD_REV_RST;
    end else if (wr_build) begin
      year_r <= build_new[31:25];
      day_r  <= build_new[24:16];
      rev_r  <= build_new[15:10];
    end
  end

  // Change flag: a new change wins over the clear at packet start
  wire ctx_change = wr_sid || wr_build || wr_org || mark_chg;
  wire pkt_start  = (state_r == ST_IDLE) && start_req;

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      changed_r <= 1'b1;
    end else if (ctx_change) begin
      changed_r <= 1'b1;
    end else if (pkt_start) begin
      changed_r <= 1'b0;
    end
  end

  // Free-running time base
  wire [63:0] ps_step = 64'(CLK_PS);
  wire        sec_wrap = (ps_r + ps_step) >= PS_PER_SECOND;

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      sec_r <= 32'h0;
      ps_r  <= 64'h0;
    end else if (sec_wrap) begin
      sec_r <= sec_r + 32'h1;
      ps_r  <= ps_r + ps_step - PS_PER_SECOND;
    end else begin
      ps_r  <= ps_r + ps_step;
    end
  end

  // Sender state machine
  // Only a word actually on the link can be taken
  wire word_taken = busy && TX_VALID && TX_READY;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_req) begin
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (word_taken && idx_r == PKT_LAST_IDX) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Snapshot at start so the words stay coherent while the link stalls
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      sec_snap_r <= 32'h0;
      ps_snap_r  <= 64'h0;
      chg_snap_r <= 1'b0;
      tsi_r      <= 2'h1;
    end else if (pkt_start) begin
      sec_snap_r <= sec_r;
      ps_snap_r  <= ps_r;
      chg_snap_r <= changed_r;
      tsi_r      <= WB_DAT_I[3:2];
    end
  end

  // Index of the word on the link, sequence number and sent count
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      idx_r      <= 4'h0;
      seq_r      <= 4'h0;
      sent_cnt_r <= 16'h0;
    end else if (pkt_start) begin
      idx_r <= 4'h0;
    end else if (word_taken) begin
      idx_r <= idx_r + 4'h1;
      if (idx_r == PKT_LAST_IDX) begin
        seq_r      <= seq_r + 4'h1;
        sent_cnt_r <= sent_cnt_r + 16'h1;
      end
    end
  end

  // Peer result flags
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      rx_good_seen_r <= 1'b0;
      rx_bad_seen_r  <= 1'b0;
    end else if (rx_done) begin
      rx_good_seen_r <= rx_good;
      rx_bad_seen_r  <= !rx_good;
    end
  end

  // Word assembly
  wire [31:0] hdr_word = {PKT_TYPE_VERSION, 1'b1, 2'b00, 1'b1, tsi_r, FRAC_TIME_REALTIME, seq_r, PKT_SIZE_WORDS};
  wire [31:0] cls0     = {5'h00, 3'h0, org_id_r[23:0]};
  wire [31:0] cls1     = {INFO_CLASS_DEFAULT, PKT_CLASS_VERSION};
  wire [31:0] cif0     = chg_snap_r ? CIF_FIRST_CHANGED : CIF_FIRST_STEADY;
  wire [31:0] ver_word = {year_r, day_r, rev_r, DEVICE_TYPE_NONE, IFREV_MAJOR1};

  // Word to load: the first one at start, else the one after the word being taken
  wire [3:0]  sel_idx = TX_VALID ? idx_r + 4'h1 : idx_r;

  wire [31:0] word_sel =
      (sel_idx == 4'h0) ? hdr_word :
      (sel_idx == 4'h1) ? stream_id_r :
      (sel_idx == 4'h2) ? cls0 :
      (sel_idx == 4'h3) ? cls1 :
      (sel_idx == 4'h4) ? sec_snap_r :
      (sel_idx == 4'h5) ? ps_snap_r[63:32] :
      (sel_idx == 4'h6) ? ps_snap_r[31:0] :
      (sel_idx == 4'h7) ? cif0 :
      (sel_idx == 4'h8) ? CIF_SECOND_VALUE :
      (sel_idx == 4'h9) ? PROTO_VERSION :
      ver_word;

  // Registered output; a stalled word holds until the far side takes it
  wire load_word = busy && (!TX_VALID || word_taken);

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      TX_VALID <= 1'b0;
      TX_LAST  <= 1'b0;
      TX_DATA  <= 32'h0;
    end else if (word_taken && idx_r == PKT_LAST_IDX) begin
      TX_VALID <= 1'b0;
      TX_LAST  <= 1'b0;
    end else if (load_word) begin
      TX_VALID <= 1'b1;
      TX_DATA  <= word_sel;
      TX_LAST  <= (sel_idx == PKT_LAST_IDX);
    end
  end

  // Registered again so the pin comes straight from a flip-flop
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      PEER_COMPAT <= 1'b0;
    end else begin
      PEER_COMPAT <= rx_compat;
    end
  end
endmodule
`default_nettype wire

// >>> tb/vpkt_builder_asserts.sv
// Port assertions for the version context packet builder
`timescale 1ns/1ps
`default_nettype none
module vpkt_builder_asserts (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        NRST,
  // Register bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  // Packet links
  input wire logic        TX_VALID,
  input wire logic        TX_LAST,
  input wire logic [31:0] TX_DATA,
  input wire logic        TX_READY,
  input wire logic        RX_VALID,
  input wire logic        RX_LAST,
  input wire logic        PEER_COMPAT
);
  logic [3:0] idx_r;
  logic       rx_end;
  assign rx_end = RX_VALID && RX_LAST;
  // Word position follows accepted words only
  always_ff @(posedge REF_CLK) begin
    if (!NRST) idx_r <= 4'h0;
    else if (TX_VALID && TX_READY) idx_r <= TX_LAST ? 4'h0 : idx_r + 4'h1;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  chk_type_field: assert property (TX_VALID && idx_r == 4'h0 |-> TX_DATA[31:28] == 4'h4)
    else $error("packet type wrong");
  chk_coarse_mode: assert property (TX_VALID && idx_r == 4'h0 |-> TX_DATA[24])
    else $error("timestamp mode bit low");
  chk_frac_type: assert property (TX_VALID && idx_r == 4'h0 |-> TX_DATA[21:20] == 2'h2)
    else $error("fraction type wrong");
  chk_size_field: assert property (TX_VALID && idx_r == 4'h0 |-> TX_DATA[15:0] == 16'h000b)
    else $error("size field wrong");
  chk_last_index: assert property (TX_VALID && TX_LAST |-> idx_r == 4'ha)
    else $error("last word at wrong place");
  chk_pad_zero: assert property (TX_VALID && idx_r == 4'h2 |-> TX_DATA[31:27] == 5'h00)
    else $error("pad count not zero");
  chk_class_code: assert property (TX_VALID && idx_r == 4'h3 |-> TX_DATA[15:0] == 16'h0004)
    else $error("class code wrong");
  chk_cif_first: assert property (TX_VALID && idx_r == 4'h7 |-> TX_DATA inside {32'h80000002, 32'h00000002})
    else $error("first indicator wrong");
  chk_cif_second: assert property (TX_VALID && idx_r == 4'h8 |-> TX_DATA == 32'h0000000c)
    else $error("second indicator wrong");
  chk_proto_word: assert property (TX_VALID && idx_r == 4'h9 |-> TX_DATA == 32'h00000004)
    else $error("protocol version wrong");
  chk_type_rev: assert property (TX_VALID && idx_r == 4'ha |-> TX_DATA[9:0] == 10'h000)
    else $error("device type or revision code set");
  chk_word_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("word changed while stalled");
  chk_compat_cause: assert property ($rose(PEER_COMPAT) |-> $past(rx_end, 2))
    else $error("compat rose without a packet end");
  chk_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not a one cycle answer");
  cov_packet_end: cover property (TX_VALID && TX_READY && TX_LAST);
  cov_stall: cover property (TX_VALID && !TX_READY);
  cov_compat: cover property ($rose(PEER_COMPAT));
endmodule
bind vpkt_builder vpkt_builder_asserts i_chk (.REF_CLK, .NRST, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .TX_VALID, .TX_LAST,
  .TX_DATA, .TX_READY, .RX_VALID, .RX_LAST, .PEER_COMPAT);
`default_nettype wire

// >>> tb/peer_endpoint_model.sv
// Peer endpoint model: takes the outgoing packet and answers with its own copy
`timescale 1ns/1ps
`default_nettype none
module peer_endpoint_model (
  // Clock and test controls
  input wire logic         clk,
  input wire logic         slow,
  input wire logic         corrupt,
  // Words from the block
  input wire logic         tx_valid,
  input wire logic         tx_last,
  input wire logic [31:0]  tx_data,
  output logic             tx_ready = 1'b0,
  // Words to the block
  output logic             rx_valid = 1'b0,
  output logic             rx_last  = 1'b0,
  output logic [31:0]      rx_data  = 32'h0
);
  logic [31:0] w [0:10];
  logic [3:0]  n    = 4'h0;
  logic [3:0]  k    = 4'h0;
  logic        busy = 1'b0;
  logic        gap  = 1'b0;
  always @(posedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    gap      <= ~gap;
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    // Idle data line shows the inverse of its last value, toggling every cycle
    rx_data  <= ~rx_data;
    if (tx_valid && tx_ready) begin
      // Corrupt run swaps in a command class code
      w[n] <= (corrupt && n == 4'h3) ? 32'h00010005 : tx_data;
      n    <= tx_last ? 4'h0 : n + 4'h1;
      busy <= tx_last;
      k    <= 4'h0;
    end else if (busy && !(slow && gap)) begin
      rx_valid <= 1'b1;
      rx_data  <= w[k];
      rx_last  <= k == 4'ha;
      k        <= k + 4'h1;
      busy     <= k != 4'ha;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Testbench for the version context packet builder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, (a), (e)); end end
module tb_top
  import vpkt_pkg::*;
;
  localparam logic [31:0] BLD = 32'h332c0800;
  logic        REF_CLK, NRST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, TX_VALID, TX_LAST, TX_READY;
  logic        RX_VALID, RX_LAST, PEER_COMPAT, slow, corrupt;
  logic [7:0]  WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, TX_DATA, RX_DATA, q;
  logic [31:0] words [$];
  int          num_errors = 0, checked = 0, cycles = 0;
  vpkt_builder i_dut (.REF_CLK, .NRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O,
    .WB_ACK_O, .TX_VALID, .TX_LAST, .TX_DATA, .TX_READY, .RX_VALID, .RX_LAST, .RX_DATA, .PEER_COMPAT);
  peer_endpoint_model i_peer (.clk(REF_CLK), .slow, .corrupt, .tx_valid(TX_VALID), .tx_last(TX_LAST),
    .tx_data(TX_DATA), .tx_ready(TX_READY), .rx_valid(RX_VALID), .rx_last(RX_LAST), .rx_data(RX_DATA));
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) words.push_back(TX_DATA);
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge REF_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_SEL_I <= 4'hf;
    WB_DAT_I <= d;
    do @(posedge REF_CLK); while (WB_ACK_O !== 1'b1);
    r = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic wait_status(input int b);
    q = 32'h0;
    for (int i = 0; i < 200 && q[b] !== 1'b1; i++) wb(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[b], 1'b1)
  endtask
  task automatic chk_pkt(input int b, input logic [31:0] cif);
    `CHK(words[b] & 32'hfff0ffff, 32'h4960000b)
    `CHK(words[b+1], 32'h12345678)
    `CHK(words[b+2], 32'h00000000)
    `CHK(words[b+3], 32'h00010004)
    `CHK(words[b+4], 32'h0)
    `CHK({words[b+5], words[b+6]} < PS_PER_SECOND, 1'b1)
    `CHK({words[b+5], words[b+6]} % CLK_PERIOD_PS, 64'h0)
    `CHK(words[b+7], cif)
    `CHK(words[b+8], 32'h0000000c)
    `CHK(words[b+9], 32'h00000004)
    `CHK(words[b+10], BLD)
  endtask
  initial begin
    NRST     = 1'b0;
    WB_CYC_I = 1'b0;
    WB_STB_I = 1'b0;
    WB_WE_I  = 1'b0;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'hf;
    WB_DAT_I = 32'h0;
    slow     = 1'b1;
    corrupt  = 1'b1;
    repeat (4) @(posedge REF_CLK);
    NRST <= 1'b1;
    rd(REG_STREAM_ID, 32'h0);
    rd(REG_BUILD, 32'h00010400);
    rd(REG_ORG_ID, 32'h0);
    rd(REG_CTRL, 32'h2);
    rd(8'h1c, 32'h0);
    $display("test reset values done");
    wb(1'b1, REG_STREAM_ID, 32'h12345678, q);
    wb(1'b1, REG_BUILD, BLD, q);
    wb(1'b1, 8'h1c, 32'hffffffff, q);
    rd(8'h1c, 32'h0);
    rd(REG_BUILD, BLD);
    $display("test register access done");
    // Second start lands while busy and must not add a packet
    wb(1'b1, REG_CTRL, 32'h5, q);
    wb(1'b1, REG_CTRL, 32'h5, q);
    wait_status(3);
    `CHK(words.size(), 11)
    chk_pkt(0, CIF_FIRST_CHANGED);
    `CHK(PEER_COMPAT, 1'b0)
    rd(REG_CTRL, 32'h0);
    rd(REG_PEER_VER, 32'h0);
    rd(REG_STATUS, 32'h00010008);
    $display("test stalled packet with bad answer done");
    slow    <= 1'b0;
    corrupt <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h5, q);
    for (int i = 0; i < 300 && PEER_COMPAT !== 1'b1; i++) @(posedge REF_CLK);
    `CHK(words.size(), 22)
    chk_pkt(11, CIF_FIRST_STEADY);
    `CHK(PEER_COMPAT, 1'b1)
    rd(REG_PEER_VER, PROTO_VERSION);
    rd(REG_PEER_BUILD, BLD);
    rd(REG_STATUS, 32'h00020006);
    $display("test steady packet with good answer done");
    report_and_stop();
  end
endmodule
`default_nettype wire
